/* File: include/css_pkg.sv */
package css_pkg;
	// Register indices; byte address is four times the index
	localparam logic [19:0] IDX_KA_SUB       = 20'h1060A;
	localparam logic [19:0] IDX_BACKUP       = 20'h1060B;
	localparam logic [19:0] IDX_OW_SUB       = 20'h1060F;
	localparam logic [19:0] IDX_SYM_SUB      = 20'h10619;
	localparam logic [19:0] IDX_ZONE_SEL     = 20'h1061A;
	localparam logic [19:0] IDX_PAGE_RD      = 20'h1061C;
	localparam logic [19:0] IDX_RS_SUB       = 20'h1061D;
	localparam logic [19:0] IDX_EXEC         = 20'h1061E;
	localparam logic [19:0] IDX_KL_SUB       = 20'h1061F;
	localparam logic [19:0] IDX_AES_SLOT     = 20'h10620;
	localparam logic [19:0] IDX_KL_CTRL      = 20'h10622;
	localparam logic [19:0] IDX_RS_CTRL      = 20'h10623;
	localparam logic [19:0] IDX_AUTH_CTRL    = 20'h10624;
	localparam logic [19:0] IDX_PW_LOC       = 20'h10626;
	localparam logic [19:0] IDX_PERM_STAT    = 20'h10627;
	localparam int          ADDR_W           = 20;
	localparam int          DATA_W           = 32;

	// Reset values
	localparam logic [2:0]  RST_SUB3         = 3'h0;
	localparam logic [3:0]  RST_SUB4         = 4'h0;
	localparam logic [7:0]  RST_ZONE_SEL     = 8'h00;
	localparam logic [2:0]  RST_PW_LOC       = 3'h1;

	// Sub-state codes
	localparam logic [2:0]  SUB_STANDBY      = 3'h1;
	localparam logic [2:0]  KA_KEYGEN        = 3'h2;
	localparam logic [2:0]  KA_CRYPT         = 3'h3;
	localparam logic [2:0]  OW_DESTROY1      = 3'h4;
	localparam logic [3:0]  SYM_RUNREADY     = 4'h4;
	localparam logic [3:0]  SYM_RS_CREATE    = 4'h8;
	localparam logic [3:0]  SYM_KEY_LOAD     = 4'h9;
	localparam logic [3:0]  SYM_INT_LO       = 4'hA;
	localparam logic [3:0]  SYM_INT_HI       = 4'hD;
	localparam logic [3:0]  SYM_DEC_WRITE    = 4'hE;
	localparam logic [3:0]  SYM_ENC_READ     = 4'hF;
	localparam logic [2:0]  RS_WR_EEP        = 3'h4;
	localparam logic [2:0]  RS_WR_BUF        = 3'h7;
	localparam logic [2:0]  KL_WR_EEP        = 3'h4;
	localparam logic [2:0]  PW_SUPER         = 3'h5;

	// Field positions
	localparam int          ZS_SLICE_LSB     = 6;
	localparam int          ZS_SUBPG_LSB     = 4;
	localparam int          KL_SAVE_BIT      = 4;
	localparam int          KL_TEXT_LSB      = 2;
	localparam int          RS_DIRECT_BIT    = 6;
	localparam int          RS_INDEX_LSB     = 4;
	localparam int          RS_SAVE_BIT      = 2;
	localparam int          RS_UPPER_BIT     = 1;
	localparam int          AUTH_DONE_BIT    = 1;
	localparam int          PERM_UID_BIT     = 0;
	localparam int          PERM_W           = 6;

	// User zone address map
	localparam logic [3:0]  ZONE_RESERVED    = 4'h0;
	localparam logic [3:0]  UZ_ADDR_TOP      = 4'hF;
	localparam logic [5:0]  UZ_SUBPG_LOW     = 6'h00;
	localparam logic [1:0]  RS_IDX_BLOCK1    = 2'h1;
	localparam logic [1:0]  RS_IDX_BLOCK3    = 2'h3;
	localparam logic [6:0]  SLICE_LOW        = 7'h00;
endpackage

/* File: rtl/css_regs.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
// Function
// - Key-agreement field: standby, keygen, crypt codes.
// - Backup bit starts sequence; zero means finished.
// - Overwrite field: standby, detour, destroy0, destroy1.
// - Symmetric field selects eight host-visible sub-states.
// - Codes E/F: decrypt-write, encrypt-read activity.
// - Fifteen zones, four pages, four subpages.
// - Bits 7:6 pick 128-bit page slice.
// - Bits 5:4 pick subpage address range.
// - Bits 3:0 pick zone; zero reserved.
// - Any write loads one page into buffer.
// - Root-serial steps run on execute write.
// - Key-load save select: decrypt or text.
// - Key-load text select feeds decryptor text.
// - Key-load key select feeds decryptor key.
// - Root-serial index names key to create/read.
// - Slot-3 direct read needs UID, index not 1/3.
// - Auth direction bit; writing one completes.
// - Password location, reset one, picks password.
// - Read-only permission flags from password logic.
module css_regs
	import css_pkg::*;
(
	input  wire logic                     I_CLK_SYS,
	input  wire logic                     I_RST_N,
	input  wire logic                     I_PSEL,
	input  wire logic                     I_PENABLE,
	input  wire logic                     I_PWRITE,
	input  wire logic [css_pkg::ADDR_W-1:0] I_PADDR,
	input  wire logic [css_pkg::DATA_W-1:0] I_PWDATA,
	input  wire logic [3:0]               I_PSTRB,
	output logic      [css_pkg::DATA_W-1:0] O_PRDATA,
	output logic                          O_PREADY,
	output logic                          O_PSLVERR,
	input  wire logic                     I_BACKUP_DONE,
	input  wire logic [css_pkg::PERM_W-1:0] I_PERM_STATUS,
	output logic      [2:0]               O_KA_STATE,
	output logic                          O_BACKUP_BUSY,
	output logic      [2:0]               O_OW_STATE,
	output logic      [3:0]               O_SYM_STATE,
	output logic                          O_DEC_WRITE_ACT,
	output logic                          O_ENC_READ_ACT,
	output logic      [1:0]               O_SLICE_SEL,
	output logic      [8:0]               O_SLICE_LSB,
	output logic      [1:0]               O_SUBPAGE_SEL,
	output logic      [3:0]               O_ZONE_SEL,
	output logic      [15:0]              O_UZ_ADDR,
	output logic                          O_PAGE_READ_STB,
	output logic      [2:0]               O_RS_STATE,
	output logic      [2:0]               O_KL_STATE,
	output logic                          O_EXEC_STB,
	output logic      [1:0]               O_AES_SLOT,
	output logic                          O_KL_SAVE_SEL,
	output logic      [1:0]               O_KL_TEXT_SEL,
	output logic      [1:0]               O_KL_KEY_SEL,
	output logic      [1:0]               O_RS_INDEX,
	output logic                          O_SLOT3_READ_EN,
	output logic                          O_RND_UPPER,
	output logic                          O_RND_LOWER,
	output logic                          O_RSC_SAVE_SEL,
	output logic                          O_AUTH_DIR,
	output logic                          O_AUTH_DONE_STB,
	output logic      [2:0]               O_PW_LOC,
	output logic      [css_pkg::PERM_W-1:0] O_PERM_STATUS
);
	import css_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] idx;
	logic              setup;
	logic              wr_en;
	logic              hit;
	logic              ro_hit;
	logic [7:0]        wd;
	logic [2:0]        ka_q;
	logic              backup_q;
	logic [2:0]        ow_q;
	logic [3:0]        sym_q;
	logic [7:0]        zone_q;
	logic [2:0]        rs_q;
	logic [2:0]        kl_q;
	logic [1:0]        slot_q;
	logic [4:0]        klc_q;
	logic [6:0]        rsc_q;
	logic              dir_q;
	logic [2:0]        pw_q;
	logic [PERM_W-1:0] perm_q;
	logic [7:0]        rd_byte;

	assign idx   = {2'b00, I_PADDR[ADDR_W-1:2]};
	assign setup = I_PSEL && !I_PENABLE;
	// Byte lane 0 carries every field; other lanes are ignored
	assign wr_en = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0] && !O_PSLVERR;
	assign wd    = I_PWDATA[7:0];

	always_comb begin
		hit    = 1'b1;
		ro_hit = 1'b0;
		unique case (idx)
			IDX_KA_SUB, IDX_BACKUP, IDX_OW_SUB, IDX_SYM_SUB, IDX_ZONE_SEL, IDX_PAGE_RD, IDX_RS_SUB,
			IDX_EXEC, IDX_KL_SUB, IDX_AES_SLOT, IDX_KL_CTRL, IDX_RS_CTRL, IDX_AUTH_CTRL,
			IDX_PW_LOC:    hit    = 1'b1;
			IDX_PERM_STAT: ro_hit = 1'b1;
			default:       hit    = 1'b0;
		endcase
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_KA_SUB:    rd_byte = {5'h00, ka_q};
			IDX_BACKUP:    rd_byte = {7'h00, backup_q};
			IDX_OW_SUB:    rd_byte = {5'h00, ow_q};
			IDX_SYM_SUB:   rd_byte = {4'h0, sym_q};
			IDX_ZONE_SEL:  rd_byte = zone_q;
			IDX_RS_SUB:    rd_byte = {5'h00, rs_q};
			IDX_KL_SUB:    rd_byte = {5'h00, kl_q};
			IDX_AES_SLOT:  rd_byte = {6'h00, slot_q};
			IDX_KL_CTRL:   rd_byte = {3'h0, klc_q};
			IDX_RS_CTRL:   rd_byte = {1'b0, rsc_q};
			IDX_AUTH_CTRL: rd_byte = {7'h00, dir_q};
			IDX_PW_LOC:    rd_byte = {5'h00, pw_q};
			IDX_PERM_STAT: rd_byte = {2'h0, perm_q};
			default:       rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// APB answer: no wait state, decided in the setup cycle
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= setup;
			// Unmapped index or write to the status word is an error
			O_PSLVERR <= setup && (!(hit || ro_hit) || (ro_hit && I_PWRITE));
			O_PRDATA  <= (setup && !I_PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Sub-state fields
	// ----------------------------------------------------------------
	logic wr_ka;
	logic wr_ow;
	logic wr_sym;
	logic wr_rs;
	logic wr_kl;
	logic sym_ok;

	assign wr_ka  = wr_en && (idx == IDX_KA_SUB);
	assign wr_ow  = wr_en && (idx == IDX_OW_SUB);
	assign wr_sym = wr_en && (idx == IDX_SYM_SUB);
	assign wr_rs  = wr_en && (idx == IDX_RS_SUB);
	assign wr_kl  = wr_en && (idx == IDX_KL_SUB);
	// Codes A..D belong to the hardware's own sequencing
	assign sym_ok = (wd[3:0] >= {1'b0, SUB_STANDBY} && wd[3:0] <= SYM_RUNREADY) || wd[3:0] == SYM_RS_CREATE ||
			wd[3:0] == SYM_KEY_LOAD || wd[3:0] >= SYM_DEC_WRITE;

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ka_q <= RST_SUB3;
		end else if (wr_ka && wd[2:0] >= SUB_STANDBY && wd[2:0] <= KA_CRYPT) begin
			ka_q <= wd[2:0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ow_q <= RST_SUB3;
		end else if (wr_ow && wd[2:0] >= SUB_STANDBY && wd[2:0] <= OW_DESTROY1) begin
			ow_q <= wd[2:0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			sym_q <= RST_SUB4;
		end else if (wr_sym && sym_ok) begin
			sym_q <= wd[3:0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			rs_q <= RST_SUB3;
		end else if (wr_rs && ((wd[2:0] >= SUB_STANDBY && wd[2:0] <= RS_WR_EEP) || wd[2:0] == RS_WR_BUF)) begin
			rs_q <= wd[2:0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			kl_q <= RST_SUB3;
		end else if (wr_kl && wd[2:0] >= SUB_STANDBY && wd[2:0] <= KL_WR_EEP) begin
			kl_q <= wd[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Counter backup: host starts, sequence end clears
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			backup_q <= 1'b0;
		end else if (wr_en && idx == IDX_BACKUP) begin
			// A start written with a done pulse still wins
			backup_q <= wd[0];
		end else if (I_BACKUP_DONE) begin
			backup_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Plain configuration fields
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			zone_q <= RST_ZONE_SEL;
			slot_q <= 2'h0;
			klc_q  <= 5'h00;
			rsc_q  <= 7'h00;
			dir_q  <= 1'b0;
			pw_q   <= RST_PW_LOC;
		end else if (wr_en) begin
			if (idx == IDX_ZONE_SEL) begin
				zone_q <= wd;
			end
			if (idx == IDX_AES_SLOT) begin
				slot_q <= wd[1:0];
			end
			if (idx == IDX_KL_CTRL) begin
				klc_q <= wd[4:0];
			end
			if (idx == IDX_RS_CTRL) begin
				rsc_q <= wd[6:0];
			end
			if (idx == IDX_AUTH_CTRL) begin
				dir_q <= wd[0];
			end
			if (idx == IDX_PW_LOC) begin
				pw_q <= wd[2:0];
			end
		end
	end

	// Status is sampled every cycle from same-clock password logic
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			perm_q <= '0;
		end else begin
			perm_q <= I_PERM_STATUS;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs toward the crypto engine
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_PAGE_READ_STB <= 1'b0;
			O_EXEC_STB      <= 1'b0;
			O_AUTH_DONE_STB <= 1'b0;
		end else begin
			// Written value is ignored for page read and execute
			O_PAGE_READ_STB <= wr_en && idx == IDX_PAGE_RD;
			O_EXEC_STB      <= wr_en && idx == IDX_EXEC;
			O_AUTH_DONE_STB <= wr_en && idx == IDX_AUTH_CTRL && wd[AUTH_DONE_BIT];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_KA_STATE      <= RST_SUB3;
			O_BACKUP_BUSY   <= 1'b0;
			O_OW_STATE      <= RST_SUB3;
			O_SYM_STATE     <= RST_SUB4;
			O_DEC_WRITE_ACT <= 1'b0;
			O_ENC_READ_ACT  <= 1'b0;
			O_RS_STATE      <= RST_SUB3;
			O_KL_STATE      <= RST_SUB3;
		end else begin
			O_KA_STATE      <= ka_q;
			O_BACKUP_BUSY   <= backup_q;
			O_OW_STATE      <= ow_q;
			O_SYM_STATE     <= sym_q;
			O_DEC_WRITE_ACT <= sym_q == SYM_DEC_WRITE;
			O_ENC_READ_ACT  <= sym_q == SYM_ENC_READ;
			O_RS_STATE      <= rs_q;
			O_KL_STATE      <= kl_q;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_SLICE_SEL   <= 2'h0;
			O_SLICE_LSB   <= 9'h000;
			O_SUBPAGE_SEL <= 2'h0;
			O_ZONE_SEL    <= ZONE_RESERVED;
			O_UZ_ADDR     <= 16'h0000;
		end else begin
			O_SLICE_SEL   <= zone_q[7:ZS_SLICE_LSB];
			O_SLICE_LSB   <= {zone_q[7:ZS_SLICE_LSB], SLICE_LOW};
			O_SUBPAGE_SEL <= zone_q[5:ZS_SUBPG_LSB];
			O_ZONE_SEL    <= zone_q[3:0];
			// Reserved zone gives no address
			O_UZ_ADDR     <= (zone_q[3:0] == ZONE_RESERVED) ? 16'h0000 :
					{UZ_ADDR_TOP, zone_q[3:0], zone_q[5:ZS_SUBPG_LSB], UZ_SUBPG_LOW};
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_AES_SLOT      <= 2'h0;
			O_KL_SAVE_SEL   <= 1'b0;
			O_KL_TEXT_SEL   <= 2'h0;
			O_KL_KEY_SEL    <= 2'h0;
			O_RS_INDEX      <= 2'h0;
			O_SLOT3_READ_EN <= 1'b0;
			O_RND_UPPER     <= 1'b0;
			O_RND_LOWER     <= 1'b0;
			O_RSC_SAVE_SEL  <= 1'b0;
			O_AUTH_DIR      <= 1'b0;
			O_PW_LOC        <= RST_PW_LOC;
			O_PERM_STATUS   <= '0;
		end else begin
			O_AES_SLOT      <= slot_q;
			O_KL_SAVE_SEL   <= klc_q[KL_SAVE_BIT];
			O_KL_TEXT_SEL   <= klc_q[3:KL_TEXT_LSB];
			O_KL_KEY_SEL    <= klc_q[1:0];
			O_RS_INDEX      <= rsc_q[5:RS_INDEX_LSB];
			// Slots tied to index 1 and 3 never leak through this path
			O_SLOT3_READ_EN <= rsc_q[RS_DIRECT_BIT] && perm_q[PERM_UID_BIT] &&
					rsc_q[5:RS_INDEX_LSB] != RS_IDX_BLOCK1 && rsc_q[5:RS_INDEX_LSB] != RS_IDX_BLOCK3;
			O_RND_UPPER     <= rsc_q[RS_UPPER_BIT];
			O_RND_LOWER     <= rsc_q[0];
			O_RSC_SAVE_SEL  <= rsc_q[RS_SAVE_BIT];
			O_AUTH_DIR      <= dir_q;
			O_PW_LOC        <= pw_q;
			O_PERM_STATUS   <= perm_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	ka_reserved_a: assert property (
		wr_ka && (wd[2:0] == 3'h0 || wd[2:0] > 3'h3) |=> $stable(ka_q))
		else $error("key agreement took reserved code");
	ka_state_out_a: assert property (
		wr_ka && wd[2:0] == 3'h2 |=> ##1 O_KA_STATE == 3'h2)
		else $error("key generation code not reflected");
	ow_reserved_a: assert property (
		wr_ow && wd[2:0] >= 3'h5 |=> ##1 $stable(O_OW_STATE))
		else $error("overwrite state moved on reserved code");
	sym_internal_a: assert property (
		wr_sym && wd[3:0] >= 4'hA && wd[3:0] <= 4'hD |=> $stable(sym_q))
		else $error("host entered internal symmetric code");
	dec_write_a: assert property (
		O_DEC_WRITE_ACT |-> $past(sym_q) == 4'hE && !O_ENC_READ_ACT)
		else $error("decrypt write flag without its code");
	backup_set_a: assert property (
		wr_en && idx == IDX_BACKUP && wd[0] |=> backup_q ##1 O_BACKUP_BUSY)
		else $error("backup start lost");
	page_read_a: assert property (
		wr_en && idx == IDX_PAGE_RD |=> O_PAGE_READ_STB ##1 !O_PAGE_READ_STB)
		else $error("page read strobe not one cycle");
	slot3_block_a: assert property (
		O_SLOT3_READ_EN |-> O_RS_INDEX != 2'h1 && O_RS_INDEX != 2'h3 && O_PERM_STATUS[0])
		else $error("slot three read while blocked");
	uz_addr_a: assert property (
		zone_q[3:0] == 4'h3 && zone_q[5:4] == 2'h2 |=> O_UZ_ADDR == 16'hF380)
		else $error("user zone address wrong");
	pw_reset_a: assert property (
		$rose(I_RST_N) |-> O_PW_LOC == 3'h1)
		else $error("password location reset value wrong");
	apb_ready_a: assert property (
		I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
		else $error("ready not single access cycle");

	exec_c: cover property (wr_kl && wd[2:0] == 3'h1 ##[1:20] O_EXEC_STB);
	backup_c: cover property (backup_q ##[1:50] !backup_q);
	dec_write_c: cover property (O_DEC_WRITE_ACT);
	slverr_c: cover property (O_PREADY && O_PSLVERR);
endmodule

/* File: tb/css_seq_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Sequencer and password logic stand-in
// ----------------------------------------
module css_seq_model #(
	parameter int DONE_DLY = 20
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_busy,
	input  wire logic [5:0] i_grant,
	output logic            o_done,
	output logic      [5:0] o_perm
);
	logic [7:0] cnt_q;

	// Slow finish so software sees the busy bit first
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q  <= 8'h00;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_busy && !o_done) begin
				cnt_q <= cnt_q + 8'h01;
				if (cnt_q == 8'(DONE_DLY - 1)) begin
					o_done <= 1'b1;
					cnt_q  <= 8'h00;
				end
			end else begin
				cnt_q <= 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		o_perm <= i_grant;
	end
endmodule

/* File: tb/css_regs_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module css_regs_tb;
	import css_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, done, serr;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic [5:0]  perm, grant;
	logic [2:0]  ka, ow, rs, kl, pw;
	logic [3:0]  sym, cur;
	logic [1:0]  sl, sp, aes, kt, kk, ri;
	logic [3:0]  zn;
	logic [8:0]  slsb;
	logic [15:0] uz;
	logic        busy, dec, enc, prs, exs, ksv, s3, ru, rl, rsv, adir, ads;
	logic [5:0]  pst;
	int          n_mismatch, checks_done, n_pg, n_ex, n_ad;
	logic [19:0] ix [5];
	logic [15:0] msk [5];
	int          nc [5];

	css_regs css_regs_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_BACKUP_DONE(done), .I_PERM_STATUS(perm),
		.O_KA_STATE(ka), .O_BACKUP_BUSY(busy), .O_OW_STATE(ow), .O_SYM_STATE(sym),
		.O_DEC_WRITE_ACT(dec), .O_ENC_READ_ACT(enc), .O_SLICE_SEL(sl), .O_SLICE_LSB(slsb),
		.O_SUBPAGE_SEL(sp), .O_ZONE_SEL(zn), .O_UZ_ADDR(uz), .O_PAGE_READ_STB(prs), .O_RS_STATE(rs),
		.O_KL_STATE(kl), .O_EXEC_STB(exs), .O_AES_SLOT(aes), .O_KL_SAVE_SEL(ksv), .O_KL_TEXT_SEL(kt),
		.O_KL_KEY_SEL(kk), .O_RS_INDEX(ri), .O_SLOT3_READ_EN(s3), .O_RND_UPPER(ru), .O_RND_LOWER(rl),
		.O_RSC_SAVE_SEL(rsv), .O_AUTH_DIR(adir), .O_AUTH_DONE_STB(ads), .O_PW_LOC(pw),
		.O_PERM_STATUS(pst));

	css_seq_model css_seq_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_busy(busy), .i_grant(grant),
		.o_done(done), .o_perm(perm));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Pulse counters, so strobe timing need not be guessed
	always @(posedge clk) begin
		n_pg += int'(prs === 1'b1);
		n_ex += int'(exs === 1'b1);
		n_ad += int'(ads === 1'b1);
	end

	// ----------------------------------------
	// APB master
	// ----------------------------------------
	task automatic xfer(input logic [19:0] i, input logic w, input logic [7:0] d, input logic [3:0] st);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= 20'(i << 2);
		pwdata  <= {24'hA5A5A5, d};
		pstrb   <= st;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat    = prdata;
		serr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic wr(input logic [19:0] i, input logic [7:0] d, input logic [3:0] st = 4'hF);
		xfer(i, 1'b1, d, st);
	endtask

	task automatic rd(input logic [19:0] i, input logic [7:0] e, input logic er, input string nm);
		xfer(i, 1'b0, 8'h00, 4'h0);
		`CHK("slave error", er, serr)
		if (!er) `CHK(nm, {24'h0, e}, rdat)
	endtask

	function automatic logic [3:0] st_out(input logic [19:0] i);
		case (i)
			IDX_KA_SUB: return {1'b0, ka};
			IDX_OW_SUB: return {1'b0, ow};
			IDX_RS_SUB: return {1'b0, rs};
			IDX_KL_SUB: return {1'b0, kl};
			default:    return sym;
		endcase
	endfunction

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		rst_n = 1'b0;
		grant = 6'h00;
		n_mismatch = 0; checks_done = 0; n_pg = 0; n_ex = 0; n_ad = 0;
		ix  = '{IDX_KA_SUB, IDX_OW_SUB, IDX_SYM_SUB, IDX_RS_SUB, IDX_KL_SUB};
		msk = '{16'h000E, 16'h001E, 16'hC31E, 16'h009E, 16'h001E};
		nc  = '{8, 8, 16, 8, 8};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(IDX_KA_SUB, 8'h00, 1'b0, "ka reset");
		rd(IDX_ZONE_SEL, 8'h00, 1'b0, "zone reset");
		rd(IDX_KL_CTRL, 8'h00, 1'b0, "kl ctrl reset");
		rd(IDX_RS_CTRL, 8'h00, 1'b0, "rs ctrl reset");
		rd(IDX_PW_LOC, 8'h01, 1'b0, "pw reset");
		`CHK("pw out", 3'h1, pw)
		rd(IDX_SYM_SUB - 20'h1, 8'h00, 1'b1, "unmapped");
		tdone("reset");

		for (int r = 0; r < 5; r++) begin
			cur = 4'h0;
			for (int c = 0; c < nc[r]; c++) begin
				wr(ix[r], 8'(c));
				if (msk[r][c]) cur = 4'(c);
				rd(ix[r], {4'h0, cur}, 1'b0, "substate");
				`CHK("state out", cur, st_out(ix[r]))
				`CHK("dec write", cur == SYM_DEC_WRITE, dec)
				`CHK("enc read", cur == SYM_ENC_READ, enc)
			end
			wr(ix[r], 8'h01);
		end
		wr(IDX_EXEC, 8'h00);
		`CHK("exec pulses", 1, n_ex)
		tdone("substates");

		for (int k = 0; k < 4; k++) begin
			logic [3:0] z;
			z = (k == 2) ? 4'h3 : 4'(k * 5);
			wr(IDX_ZONE_SEL, {2'(k), 2'(k), z});
			rd(IDX_ZONE_SEL, {2'(k), 2'(k), z}, 1'b0, "zone sel");
			`CHK("slice", 2'(k), sl)
			`CHK("slice lsb", 9'(k * 128), slsb)
			`CHK("subpage", 2'(k), sp)
			`CHK("zone", z, zn)
			`CHK("uz addr", (z == 4'h0) ? 16'h0000 : {4'hF, z, 2'(k), 6'h00}, uz)
		end
		tdone("zone");

		wr(IDX_PAGE_RD, 8'h00);
		wr(IDX_PAGE_RD, 8'hA5);
		rd(IDX_PAGE_RD, 8'h00, 1'b0, "page rd");
		`CHK("page pulses", 2, n_pg)
		for (int k = 0; k < 4; k++) begin
			wr(IDX_KL_CTRL, 8'((k % 2) * 16 + k * 4 + k));
			wr(IDX_AES_SLOT, 8'(k));
			`CHK("save sel", 1'(k % 2), ksv)
			`CHK("text sel", 2'(k), kt)
			`CHK("key sel", 2'(k), kk)
			`CHK("aes slot", 2'(k), aes)
		end
		wr(IDX_KL_CTRL, 8'h00, 4'hE);
		rd(IDX_KL_CTRL, 8'h1F, 1'b0, "strobe off");
		tdone("key load");

		grant <= 6'h01;
		for (int k = 0; k < 4; k++) begin
			wr(IDX_RS_CTRL, 8'(64 + k * 16 + (k % 2) * 4 + k));
			repeat (3) @(posedge clk);
			`CHK("rs index", 2'(k), ri)
			`CHK("slot3 en", (k != 1 && k != 3), s3)
			`CHK("rnd upper", 1'(k / 2), ru)
			`CHK("rnd lower", 1'(k % 2), rl)
			`CHK("rsc save", 1'(k % 2), rsv)
		end
		grant <= 6'h30;
		wr(IDX_RS_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		`CHK("slot3 no uid", 1'b0, s3)
		rd(IDX_PERM_STAT, 8'h30, 1'b0, "perm");
		`CHK("perm out", 6'h30, pst)
		wr(IDX_PERM_STAT, 8'h00);
		`CHK("ro write err", 1'b1, serr)
		tdone("root serial");

		wr(IDX_AUTH_CTRL, 8'h01);
		`CHK("auth dir", 1'b1, adir)
		`CHK("auth none", 0, n_ad)
		wr(IDX_AUTH_CTRL, 8'h02);
		rd(IDX_AUTH_CTRL, 8'h00, 1'b0, "auth rd");
		`CHK("auth pulses", 1, n_ad)
		for (int k = 5; k >= 0; k--) begin
			wr(IDX_PW_LOC, 8'(k));
			rd(IDX_PW_LOC, 8'(k), 1'b0, "pw loc");
			`CHK("pw out", 3'(k), pw)
		end
		tdone("auth");

		wr(IDX_BACKUP, 8'h01);
		rd(IDX_BACKUP, 8'h01, 1'b0, "backup busy");
		`CHK("busy out", 1'b1, busy)
		repeat (30) @(posedge clk);
		rd(IDX_BACKUP, 8'h00, 1'b0, "backup done");
		`CHK("busy out", 1'b0, busy)
		tdone("backup");
		complete_run();
	end
endmodule
